/* core/pft_hold_mem.sv */
// Sixty-four byte holding memory for block programming.
// Assumes one clock; a clear in the same cycle as a write wins over the write.
`timescale 1ns/100ps
`include "pft_defines.svh"
module pft_hold_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [7:0]    wr_data,
  input  wire logic          clr_all,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [7:0]    rd_data_r
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rdata;
  } pft_hold_state_s;

  pft_hold_state_s state_r;
  pft_hold_state_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = state_r.mem[rd_idx];
    // erased pattern after a block operation.
    if (clr_all) begin
      state_nxt.mem = {DEPTH{`PFT_HOLD_ERASED}};
    end else if (wr_en) begin
      state_nxt.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= {{DEPTH{`PFT_HOLD_ERASED}}, `PFT_BYTE_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_data_r = state_r.rdata;
endmodule

/* core/pft_table_access.sv */
// Table access unit: latch, pointer, control and unlock port, table
// read and write engine and launch of self-timed block operations.
// Assumes the core, the flash array and the programming timer all run
// on clk; the timer reports completion with a one-cycle prog_done.
`timescale 1ns/100ps
`include "pft_defines.svh"
module pft_table_access (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire pft_pkg::pft_reg_req_s  reg_req,
  output logic [7:0]                  reg_rdata_r,
  input  wire pft_pkg::pft_tbl_req_s  tbl_req,
  output logic                        tbl_done_r,
  output logic                        flash_rd_req_r,
  output logic [21:0]                 flash_rd_addr_r,
  input  wire logic                   flash_rd_ack,
  input  wire logic [7:0]             flash_rd_data,
  output pft_pkg::pft_prog_cmd_s      prog_cmd_r,
  input  wire logic                   prog_done,
  input  wire logic                   prog_aborted,
  input  wire logic [5:0]             hold_rd_idx,
  output logic [7:0]                  hold_rd_data_r,
  output logic                        fetch_stall_r,
  output logic                        ee_rd_req_r,
  output logic                        nvm_done_irq_flag_r,
  input  wire logic                   irq_flag_clr
);
  typedef struct packed {
    logic [7:0]             latch;
    logic [21:0]            ptr;
    logic                   prog_space;
    logic                   cfg_space;
    logic                   row_erase;
    logic                   abort;
    logic                   permit;
    logic                   wr_go;
    logic                   rd_go;
    pft_pkg::pft_unlock_e   ul;
    pft_pkg::pft_op_e       op;
    pft_pkg::pft_ptr_mode_e mode;
    logic                   first;
    logic                   busy_erase;
    logic [7:0]             rdata;
    logic                   done;
    logic                   rd_req;
    logic [21:0]            rd_addr;
    pft_pkg::pft_prog_cmd_s cmd;
    logic                   stall;
    logic                   ee_rd;
    logic                   irq;
    logic                   clr_hold;
  } pft_state_s;

  pft_state_s state_r;
  pft_state_s state_nxt;
  logic       hold_we;

  // Steps only the low 21 bits; bit 21 selects the special space and
  // must never be reached by a carry or borrow.
  function automatic logic [21:0] ptr_step(input logic [21:0] p,
                                           input logic        up);
    logic [20:0] low;
    low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
    return {p[21], low};
  endfunction

  function automatic logic [7:0] ctrl_byte(input pft_state_s s);
    logic [7:0] b;
    b = `PFT_BYTE_RESET;
    b[`PFT_BIT_PROG_SPACE] = s.prog_space;
    b[`PFT_BIT_CFG_SPACE]  = s.cfg_space;
    b[`PFT_BIT_UNUSED]     = 1'b0;
    b[`PFT_BIT_ROW_ERASE]  = s.row_erase;
    b[`PFT_BIT_ABORT]      = s.abort;
    b[`PFT_BIT_PERMIT]     = s.permit;
    b[`PFT_BIT_WR_GO]      = s.wr_go;
    b[`PFT_BIT_RD_GO]      = s.rd_go;
    return b;
  endfunction

  always_comb begin
    logic [7:0]  w;
    logic [21:0] p;
    logic        start_req;
    logic        tbl_go;
    w         = reg_req.wdata;
    p         = state_r.ptr;
    start_req = 1'b0;
    tbl_go    = 1'b0;
    hold_we   = 1'b0;
    state_nxt = state_r;
    state_nxt.done      = 1'b0;
    state_nxt.rd_req    = 1'b0;
    state_nxt.cmd.start = 1'b0;
    state_nxt.ee_rd     = 1'b0;
    state_nxt.clr_hold  = 1'b0;
    state_nxt.first     = 1'b0;

    // a block operation cut off by reset shows at the release.
    if (state_r.first && prog_aborted) begin
      state_nxt.abort = 1'b1;
    end

    // read strobe lasts a single cycle.
    if (state_r.rd_go) begin
      state_nxt.rd_go = 1'b0;
    end

    if (reg_req.wr) begin
      // any other write breaks the unlock sequence.
      state_nxt.ul = pft_pkg::PFT_UL_IDLE;
      case (reg_req.sel)
        `PFT_SEL_CONTROL: begin
          // selects are frozen while an operation runs.
          if (!state_r.wr_go) begin
            state_nxt.prog_space = w[`PFT_BIT_PROG_SPACE];
            state_nxt.cfg_space  = w[`PFT_BIT_CFG_SPACE];
            state_nxt.row_erase  = w[`PFT_BIT_ROW_ERASE];
            state_nxt.abort      = w[`PFT_BIT_ABORT] | state_nxt.abort;
          end
          state_nxt.permit = w[`PFT_BIT_PERMIT];
          // writing zero to the start bit does nothing.
          if (w[`PFT_BIT_WR_GO] && !state_r.wr_go) begin
            start_req = 1'b1;
          end
          // read refused when either select is set.
          if (w[`PFT_BIT_RD_GO] && !w[`PFT_BIT_PROG_SPACE] &&
              !w[`PFT_BIT_CFG_SPACE] && !state_r.wr_go) begin
            state_nxt.rd_go = 1'b1;
            state_nxt.ee_rd = 1'b1;
          end
        end
        `PFT_SEL_UNLOCK: begin
          // keys must come in order with nothing between.
          if (w == `PFT_UNLOCK_KEY1) begin
            state_nxt.ul = pft_pkg::PFT_UL_GOT_KEY1;
          end else if (w == `PFT_UNLOCK_KEY2 &&
                       state_r.ul == pft_pkg::PFT_UL_GOT_KEY1) begin
            state_nxt.ul = pft_pkg::PFT_UL_ARMED;
          end
        end
        `PFT_SEL_LATCH: begin
          state_nxt.latch = w;
        end
        `PFT_SEL_PTR_UPPER: begin
          state_nxt.ptr[21:16] = w[5:0];
        end
        `PFT_SEL_PTR_HIGH: begin
          state_nxt.ptr[15:8] = w;
        end
        `PFT_SEL_PTR_LOW: begin
          state_nxt.ptr[7:0] = w;
        end
        default: begin
          state_nxt.ul = pft_pkg::PFT_UL_IDLE;
        end
      endcase
    end

    if (start_req) begin
      // need permit and an armed unlock in the previous write.
      if (state_r.permit && state_r.ul == pft_pkg::PFT_UL_ARMED) begin
        state_nxt.wr_go          = 1'b1;
        // flag raised for the life of the operation.
        state_nxt.abort          = 1'b1;
        state_nxt.cmd.start      = 1'b1;
        // only the row erase exists; no whole-array command.
        state_nxt.cmd.erase      = state_nxt.row_erase;
        state_nxt.busy_erase     = state_nxt.row_erase;
        state_nxt.cmd.prog_space = state_nxt.prog_space;
        state_nxt.cmd.cfg_space  = state_nxt.cfg_space;
        // block number from pointer bits 21 to 6.
        state_nxt.cmd.block      = state_r.ptr[21:6];
        // flash space operations stop instruction fetch.
        state_nxt.stall = state_nxt.prog_space | state_nxt.cfg_space;
      end else begin
        // an improper attempt leaves the flag set.
        state_nxt.abort = 1'b1;
      end
    end

    if (prog_done && state_r.wr_go) begin
      state_nxt.wr_go    = 1'b0;
      state_nxt.abort    = 1'b0;
      // fetch resumes when the timer finishes.
      state_nxt.stall    = 1'b0;
      // holding bytes erased after every operation.
      state_nxt.clr_hold = 1'b1;
      // erase request consumed by the erase.
      if (state_r.busy_erase) begin
        state_nxt.row_erase = 1'b0;
      end
      state_nxt.busy_erase = 1'b0;
    end

    // set wins over a clear in the same cycle.
    if (prog_done && state_r.wr_go) begin
      state_nxt.irq = 1'b1;
    end else if (irq_flag_clr) begin
      state_nxt.irq = 1'b0;
    end

    // Table operations wait while a block operation owns the array.
    tbl_go = tbl_req.valid && !state_r.wr_go &&
             state_r.op == pft_pkg::PFT_OP_IDLE;
    if (tbl_go) begin
      if (tbl_req.mode == pft_pkg::PFT_PTR_PRE_INC) begin
        p = ptr_step(state_r.ptr, 1'b1);
      end
      state_nxt.ptr  = p;
      state_nxt.mode = tbl_req.mode;
      if (tbl_req.write) begin
        // only the holding byte changes, never the array.
        hold_we = 1'b1;
        if (tbl_req.mode == pft_pkg::PFT_PTR_POST_INC) begin
          state_nxt.ptr = ptr_step(p, 1'b1);
        end else if (tbl_req.mode == pft_pkg::PFT_PTR_POST_DEC) begin
          state_nxt.ptr = ptr_step(p, 1'b0);
        end
        state_nxt.done = 1'b1;
      end else begin
        // all 22 bits address the byte read.
        state_nxt.rd_req  = 1'b1;
        state_nxt.rd_addr = p;
        state_nxt.op      = pft_pkg::PFT_OP_RD_WAIT;
      end
    end

    case (state_r.op)
      pft_pkg::PFT_OP_IDLE: begin
        state_nxt.rd_req = state_nxt.rd_req;
      end
      pft_pkg::PFT_OP_RD_WAIT: begin
        if (flash_rd_ack) begin
          // the byte lands in the table latch.
          state_nxt.latch = flash_rd_data;
          if (state_r.mode == pft_pkg::PFT_PTR_POST_INC) begin
            state_nxt.ptr = ptr_step(state_r.ptr, 1'b1);
          end else if (state_r.mode == pft_pkg::PFT_PTR_POST_DEC) begin
            state_nxt.ptr = ptr_step(state_r.ptr, 1'b0);
          end
          state_nxt.done = 1'b1;
          state_nxt.op   = pft_pkg::PFT_OP_IDLE;
        end
      end
      default: begin
        state_nxt.op = pft_pkg::PFT_OP_IDLE;
      end
    endcase

    state_nxt.rdata = `PFT_BYTE_RESET;
    if (reg_req.rd) begin
      case (reg_req.sel)
        `PFT_SEL_CONTROL: begin
          state_nxt.rdata = ctrl_byte(state_r);
        end
        `PFT_SEL_UNLOCK: begin
          // the unlock port has no storage.
          state_nxt.rdata = `PFT_BYTE_RESET;
        end
        `PFT_SEL_LATCH: begin
          state_nxt.rdata = state_r.latch;
        end
        `PFT_SEL_PTR_UPPER: begin
          state_nxt.rdata = {2'h0, state_r.ptr[21:16]};
        end
        `PFT_SEL_PTR_HIGH: begin
          state_nxt.rdata = state_r.ptr[15:8];
        end
        `PFT_SEL_PTR_LOW: begin
          state_nxt.rdata = state_r.ptr[7:0];
        end
        default: begin
          state_nxt.rdata = `PFT_BYTE_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r            <= '0;
      state_r.ptr        <= `PFT_PTR_RESET;
      state_r.ul         <= pft_pkg::PFT_UL_IDLE;
      state_r.op         <= pft_pkg::PFT_OP_IDLE;
      state_r.mode       <= pft_pkg::PFT_PTR_KEEP;
      // permit is clear out of reset.
      state_r.permit     <= 1'b0;
      state_r.first      <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the write index is the pointer seen by the access itself.
  // Everything it reads is an argument, so the connection follows it.
  function automatic logic [5:0] hold_idx_w(
    input logic [21:0]            ptr,
    input pft_pkg::pft_ptr_mode_e m);
    logic [21:0] q;
    q = ptr;
    if (m == pft_pkg::PFT_PTR_PRE_INC) begin
      q = ptr_step(ptr, 1'b1);
    end
    return q[5:0];
  endfunction

  // byte-wide holding store at any index, odd or even.
  // any value is accepted; the core decodes illegal words as no-ops.
  pft_hold_mem #(
    .DEPTH (64),
    .AW    (6)
  ) u_hold (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (hold_we),
    .wr_idx    (hold_idx_w(state_r.ptr, tbl_req.mode)),
    .wr_data   (state_r.latch),
    .clr_all   (state_r.clr_hold),
    .rd_idx    (hold_rd_idx),
    .rd_data_r (hold_rd_data_r)
  );

  assign reg_rdata_r         = state_r.rdata;
  assign tbl_done_r          = state_r.done;
  assign flash_rd_req_r      = state_r.rd_req;
  assign flash_rd_addr_r     = state_r.rd_addr;
  assign prog_cmd_r          = state_r.cmd;
  assign fetch_stall_r       = state_r.stall;
  assign ee_rd_req_r         = state_r.ee_rd;
  assign nvm_done_irq_flag_r = state_r.irq;
endmodule

/* pkg/pft_defines.svh */
// Constants of the table access unit: register selects, control bit
// positions, unlock keys and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef PFT_DEFINES_SVH
`define PFT_DEFINES_SVH

`define PFT_SEL_CONTROL     3'h0
`define PFT_SEL_UNLOCK      3'h1
`define PFT_SEL_LATCH       3'h2
`define PFT_SEL_PTR_UPPER   3'h3
`define PFT_SEL_PTR_HIGH    3'h4
`define PFT_SEL_PTR_LOW     3'h5

`define PFT_BIT_PROG_SPACE  7
`define PFT_BIT_CFG_SPACE   6
`define PFT_BIT_UNUSED      5
`define PFT_BIT_ROW_ERASE   4
`define PFT_BIT_ABORT       3
`define PFT_BIT_PERMIT      2
`define PFT_BIT_WR_GO       1
`define PFT_BIT_RD_GO       0

`define PFT_UNLOCK_KEY1     8'h55
`define PFT_UNLOCK_KEY2     8'hAA
`define PFT_HOLD_ERASED     8'hFF
`define PFT_PTR_RESET       22'h000000
`define PFT_BYTE_RESET      8'h00

`endif

/* pkg/pft_pkg.sv */
// Types shared by the table access unit, the far side model, the checker and the bench.
// Assumes pft_defines.svh is on the include path.
package pft_pkg;

  typedef enum logic [1:0] {
    PFT_UL_IDLE,
    PFT_UL_GOT_KEY1,
    PFT_UL_ARMED
  } pft_unlock_e;

  typedef enum logic [1:0] {
    PFT_OP_IDLE,
    PFT_OP_RD_WAIT
  } pft_op_e;

  typedef enum logic [1:0] {
    PFT_PTR_KEEP,
    PFT_PTR_POST_INC,
    PFT_PTR_POST_DEC,
    PFT_PTR_PRE_INC
  } pft_ptr_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } pft_reg_req_s;

  typedef struct packed {
    logic          valid;
    logic          write;
    pft_ptr_mode_e mode;
  } pft_tbl_req_s;

  typedef struct packed {
    logic        start;
    logic        erase;
    logic        prog_space;
    logic        cfg_space;
    logic [15:0] block;
  } pft_prog_cmd_s;

endpackage

/* sim/pft_far_model.sv */
// Flash array and programming timer seen from the table access unit.
// Assumes one clock; read latency and timer length come from the bench.
`timescale 1ns/100ps
module pft_far_model (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [3:0]             rd_lat,
  input wire logic [7:0]             prog_lat,
  input wire logic                   rd_req,
  input wire logic [21:0]            rd_addr,
  output logic                       rd_ack,
  output logic [7:0]                 rd_data,
  input wire pft_pkg::pft_prog_cmd_s cmd,
  output logic                       done,
  output logic [7:0]                 starts,
  output pft_pkg::pft_prog_cmd_s     last_cmd
);
  logic       pend;
  logic [3:0] cnt;
  logic [7:0] tcnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
      cnt <= 4'h0;
      rd_ack <= 1'b0;
      rd_data <= 8'h00;
      tcnt <= 8'h00;
      done <= 1'b0;
      starts <= 8'h00;
      last_cmd <= '0;
    end else begin
      rd_ack <= 1'b0;
      done <= 1'b0;
      // Data is only valid with the answer; it toggles otherwise.
      rd_data <= ~rd_data;
      if (rd_req) begin
        pend <= 1'b1;
        cnt <= rd_lat;
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        rd_ack <= 1'b1;
        rd_data <= rd_addr[7:0] ^ rd_addr[15:8] ^ {2'h0, rd_addr[21:16]};
      end
      if (cmd.start) begin
        tcnt <= prog_lat;
        starts <= starts + 8'h01;
        last_cmd <= cmd;
      end else if (tcnt == 8'h01) begin
        tcnt <= 8'h00;
        done <= 1'b1;
      end else if (tcnt != 8'h00) begin
        tcnt <= tcnt - 8'h01;
      end
    end
  end
endmodule

/* sim/pft_table_access_props.sv */
// Checker for the table access unit, watching the top module's ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module pft_table_access_props (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire pft_pkg::pft_reg_req_s reg_req,
  input wire logic [7:0]            reg_rdata_r,
  input wire pft_pkg::pft_tbl_req_s tbl_req,
  input wire logic                  tbl_done_r,
  input wire logic                  flash_rd_req_r,
  input wire logic [21:0]           flash_rd_addr_r,
  input wire logic                  flash_rd_ack,
  input wire logic [7:0]            flash_rd_data,
  input wire pft_pkg::pft_prog_cmd_s prog_cmd_r,
  input wire logic                  prog_done,
  input wire logic                  prog_aborted,
  input wire logic [5:0]            hold_rd_idx,
  input wire logic [7:0]            hold_rd_data_r,
  input wire logic                  fetch_stall_r,
  input wire logic                  ee_rd_req_r,
  input wire logic                  nvm_done_irq_flag_r,
  input wire logic                  irq_flag_clr
);
  logic busy_r;
  logic pend_r;
  logic idle;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A started block operation and an open flash read both block new ops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      busy_r <= prog_cmd_r.start | (busy_r & ~prog_done);
      pend_r <= flash_rd_req_r | (pend_r & ~tbl_done_r);
    end
  end
  assign idle = ~busy_r & ~prog_cmd_r.start & ~pend_r & ~flash_rd_req_r;
  property p_unlock_zero;
    reg_req.rd && reg_req.sel == 3'h1 |=> reg_rdata_r == 8'h00;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero)
    else $error("unlock port read not zero");
  property p_bit5_zero;
    reg_req.rd && reg_req.sel == 3'h0 |=> !reg_rdata_r[5];
  endproperty
  a_bit5_zero: assert property (p_bit5_zero)
    else $error("control bit 5 read as one");
  property p_stall_start;
    prog_cmd_r.start |->
      fetch_stall_r == (prog_cmd_r.prog_space | prog_cmd_r.cfg_space);
  endproperty
  a_stall_start: assert property (p_stall_start)
    else $error("stall does not match target space at start");
  property p_stall_hold;
    fetch_stall_r && !prog_done |=> fetch_stall_r;
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("stall dropped before timer end");
  property p_done_flag;
    prog_done |=> nvm_done_irq_flag_r && !fetch_stall_r;
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("completion did not raise flag or release stall");
  property p_flag_sticky;
    nvm_done_irq_flag_r && !irq_flag_clr |=> $stable(nvm_done_irq_flag_r);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("done flag dropped without clear");
  property p_hold_erased;
    prog_done ##1 !tbl_req.valid [*2] |=> ##1 hold_rd_data_r == 8'hFF;
  endproperty
  a_hold_erased: assert property (p_hold_erased)
    else $error("holding byte not FF after operation");
  property p_ee_refuse;
    reg_req.wr && reg_req.sel == 3'h0 && reg_req.wdata[0] &&
      (reg_req.wdata[7] || reg_req.wdata[6]) |=> !ee_rd_req_r;
  endproperty
  a_ee_refuse: assert property (p_ee_refuse)
    else $error("read start taken with a select bit set");
  property p_tbl_wr;
    idle && tbl_req.valid && tbl_req.write |=> tbl_done_r && !flash_rd_req_r;
  endproperty
  a_tbl_wr: assert property (p_tbl_wr)
    else $error("table write not finished next cycle");
  property p_tbl_rd;
    idle && tbl_req.valid && !tbl_req.write |=> flash_rd_req_r && !tbl_done_r;
  endproperty
  a_tbl_rd: assert property (p_tbl_rd)
    else $error("table read did not request flash");
  property p_rd_done;
    flash_rd_ack && (pend_r || flash_rd_req_r) |=> tbl_done_r;
  endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("table read not finished after flash answer");
  c_erase: cover property (prog_cmd_r.start && prog_cmd_r.erase);
  c_rd_slow: cover property (pend_r && flash_rd_ack);
  c_ee_read: cover property (ee_rd_req_r);
endmodule

bind pft_table_access pft_table_access_props u_props (
  .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
  .tbl_req(tbl_req), .tbl_done_r(tbl_done_r),
  .flash_rd_req_r(flash_rd_req_r), .flash_rd_addr_r(flash_rd_addr_r),
  .flash_rd_ack(flash_rd_ack), .flash_rd_data(flash_rd_data),
  .prog_cmd_r(prog_cmd_r), .prog_done(prog_done),
  .prog_aborted(prog_aborted), .hold_rd_idx(hold_rd_idx),
  .hold_rd_data_r(hold_rd_data_r), .fetch_stall_r(fetch_stall_r),
  .ee_rd_req_r(ee_rd_req_r), .nvm_done_irq_flag_r(nvm_done_irq_flag_r),
  .irq_flag_clr(irq_flag_clr));

/* sim/pft_table_access_tb.sv */
// Self-checking bench for the table access unit with its far side model.
// Assumes a 25 MHz clock and the register select codes of the defines header.
`timescale 1ns/100ps
module pft_table_access_tb;
  logic                  clk;
  logic                  rst_n;
  pft_pkg::pft_reg_req_s reg_req;
  pft_pkg::pft_tbl_req_s tbl_req;
  logic [7:0]            reg_rdata_r;
  logic                  tbl_done_r;
  logic                  rd_req;
  logic [21:0]           rd_addr;
  logic                  rd_ack;
  logic [7:0]            rd_data;
  pft_pkg::pft_prog_cmd_s cmd;
  pft_pkg::pft_prog_cmd_s last_cmd;
  logic                  done;
  logic [7:0]            starts;
  logic                  prog_aborted;
  logic [5:0]            hold_rd_idx;
  logic [7:0]            hold_rd_data_r;
  logic                  fetch_stall_r;
  logic                  ee_rd_req_r;
  logic                  flag;
  logic                  irq_flag_clr;
  logic [3:0]            rd_lat;
  int                    mismatches;
  int                    checks_done;

  pft_table_access uut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata_r(reg_rdata_r), .tbl_req(tbl_req), .tbl_done_r(tbl_done_r),
    .flash_rd_req_r(rd_req), .flash_rd_addr_r(rd_addr),
    .flash_rd_ack(rd_ack), .flash_rd_data(rd_data), .prog_cmd_r(cmd),
    .prog_done(done), .prog_aborted(prog_aborted),
    .hold_rd_idx(hold_rd_idx), .hold_rd_data_r(hold_rd_data_r),
    .fetch_stall_r(fetch_stall_r), .ee_rd_req_r(ee_rd_req_r),
    .nvm_done_irq_flag_r(flag), .irq_flag_clr(irq_flag_clr));
  pft_far_model u_far (.clk(clk), .rst_n(rst_n), .rd_lat(rd_lat),
    .prog_lat(8'h28), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
    .rd_data(rd_data), .cmd(cmd), .done(done), .starts(starts),
    .last_cmd(last_cmd));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk) reg_req <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(posedge clk) reg_req <= '0;
  endtask
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(posedge clk) reg_req <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
    @(posedge clk) reg_req <= '0;
    #1 d = reg_rdata_r;
  endtask
  task automatic rchk(input logic [2:0] s, input logic [7:0] e);
    logic [7:0] d;
    rd(s, d);
    chk(d, e);
  endtask
  task automatic setp(input logic [21:0] p);
    wr(3'h3, {2'h0, p[21:16]});
    wr(3'h4, p[15:8]);
    wr(3'h5, p[7:0]);
  endtask
  task automatic ptr_chk(input logic [21:0] p);
    rchk(3'h3, {2'h0, p[21:16]});
    rchk(3'h4, p[15:8]);
    rchk(3'h5, p[7:0]);
  endtask
  task automatic hchk(input logic [5:0] i, input logic [7:0] e);
    @(posedge clk) hold_rd_idx <= i;
    repeat (2) @(posedge clk);
    #1 chk(hold_rd_data_r, e);
  endtask
  task automatic tbl(input logic w, input pft_pkg::pft_ptr_mode_e m);
    @(posedge clk) tbl_req <= '{valid: 1'b1, write: w, mode: m};
    @(posedge clk) tbl_req <= '0;
    for (int i = 0; i < 30; i++) begin
      #1 if (tbl_done_r === 1'b1) break;
      @(posedge clk);
    end
    chk(tbl_done_r, 1'b1);
  endtask
  task automatic go(input logic [7:0] c);
    @(posedge clk) irq_flag_clr <= 1'b1;
    @(posedge clk) irq_flag_clr <= 1'b0;
    // Permit must already stand when the start bit is written.
    wr(3'h0, c & 8'hFD);
    wr(3'h1, 8'h55);
    wr(3'h1, 8'hAA);
    wr(3'h0, c);
  endtask
  task automatic wait_op;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1 if (flag === 1'b1) break;
    end
    chk(flag, 1'b1);
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset_vals;
    rchk(3'h0, 8'h00);
    rchk(3'h1, 8'h00);
    hchk(6'h00, 8'hFF);
    hchk(6'h3F, 8'hFF);
    $display("reset values done");
  endtask
  task automatic t_table_write;
    wr(3'h3, 8'hFF);
    rchk(3'h3, 8'h3F);
    setp(22'h3FFFFF);
    wr(3'h2, 8'hA5);
    tbl(1'b1, pft_pkg::PFT_PTR_POST_INC);
    hchk(6'h3F, 8'hA5);
    ptr_chk(22'h200000);
    wr(3'h2, 8'h3C);
    tbl(1'b1, pft_pkg::PFT_PTR_PRE_INC);
    hchk(6'h01, 8'h3C);
    ptr_chk(22'h200001);
    $display("table write done");
  endtask
  task automatic t_table_read;
    logic [21:0] p0[4] = '{22'h100001, 22'h100001, 22'h200000, 22'h1FFFFF};
    logic [21:0] pa[4] = '{22'h100001, 22'h100001, 22'h200000, 22'h000000};
    logic [21:0] p1[4] = '{22'h100001, 22'h100002, 22'h3FFFFF, 22'h000000};
    for (int i = 0; i < 4; i++) begin
      rd_lat = 4'(2 * i);
      setp(p0[i]);
      tbl(1'b0, pft_pkg::pft_ptr_mode_e'(i[1:0]));
      chk(rd_addr, pa[i]);
      rchk(3'h2, pa[i][7:0] ^ pa[i][15:8] ^ {2'h0, pa[i][21:16]});
      ptr_chk(p1[i]);
    end
    $display("table read done");
  endtask
  task automatic t_block_ops;
    setp(22'h2ABCDE);
    go(8'h86);
    #1 chk(fetch_stall_r, 1'b1);
    rchk(3'h0, 8'h8E);
    wr(3'h0, 8'h84);
    rchk(3'h0, 8'h8E);
    wait_op();
    rchk(3'h0, 8'h84);
    chk(last_cmd, {1'b1, 1'b0, 1'b1, 1'b0, 16'hAAF3});
    hchk(6'h01, 8'hFF);
    go(8'hD6);
    wait_op();
    chk(last_cmd, {1'b1, 1'b1, 1'b1, 1'b1, 16'hAAF3});
    rchk(3'h0, 8'hC4);
    go(8'h06);
    #1 chk(fetch_stall_r, 1'b0);
    wait_op();
    chk(last_cmd.prog_space, 1'b0);
    chk(starts, 8'h03);
    $display("block operations done");
  endtask
  task automatic t_refused;
    wr(3'h0, 8'h86);
    rchk(3'h0, 8'h8C);
    go(8'h82);
    rchk(3'h0, 8'h88);
    chk(starts, 8'h03);
    chk(flag, 1'b0);
    $display("refused starts done");
  endtask
  task automatic t_ee_read;
    wr(3'h0, 8'h01);
    #1 chk(ee_rd_req_r, 1'b1);
    wr(3'h0, 8'h81);
    #1 chk(ee_rd_req_r, 1'b0);
    rchk(3'h0, 8'h88);
    $display("data read start done");
  endtask
  task automatic t_reset_abort;
    go(8'h86);
    repeat (5) @(posedge clk);
    rst_n <= 1'b0;
    prog_aborted <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) prog_aborted <= 1'b0;
    #1 chk(fetch_stall_r, 1'b0);
    rchk(3'h0, 8'h08);
    $display("reset abort done");
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("BAD t=%0t run did not finish", $time);
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    tbl_req = '0;
    prog_aborted = 1'b0;
    hold_rd_idx = 6'h00;
    irq_flag_clr = 1'b0;
    rd_lat = 4'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_table_write();
    t_table_read();
    t_block_ops();
    t_refused();
    t_ee_read();
    t_reset_abort();
    close_out();
  end
endmodule
